// file: core/lcx_exec.v
// lcx_exec.v: fetch, decode and execute of literal and control instructions
// assumes: program memory answers combinationally on instr_word for pc_addr
// Summary of operation
// - opcode 1101 ORs literal into accumulator and updates zero flag
// - opcode 1111 XORs literal into accumulator; zero flag set on zero result
// - literal AND masks accumulator bits where literal bits are zero
// - opcode 101 loads 9-bit target into program counter
// - opcode 1001 pushes pc+1 then loads subroutine address
// - call and accumulator write to pc file force pc bit 8 low
// - return stack entries are 9 bits wide
// - return-with-literal pops pc and loads literal into accumulator
// - return-from-irq pops pc, leaves accumulator, lets pending irq through
// - only return-from-irq re-enables interrupts
// - carry lives in status file bit 0
// - digit carry lives in status file bit 1
// - file self-move rewrites value and sets zero flag if zero
// - zero flag lives in status file bit 2
`timescale 1ns/10ps
`default_nettype none
`include "lcx_defines.vh"
module lcx_exec (
  input wire clk,
  input wire reset,
  input wire ce,
  input wire [11:0] instr_word,
  input wire irq_request,
  input wire [7:0] file_rd_data,
  output reg [8:0] pc_addr,
  output reg [7:0] acc_out,
  output reg [7:0] status_out,
  output reg irq_enable,
  output reg irq_taken,
  output reg file_wr_en,
  output reg [4:0] file_addr,
  output reg [7:0] file_wr_data
);
  reg [8:0] pc_next;
  reg [7:0] acc_next;
  reg [7:0] status_next;
  reg irq_en_next;
  reg push;
  reg pop;
  reg [8:0] push_data;
  reg wr_en_next;
  reg [7:0] wr_data_next;
  reg zero_upd;
  reg [7:0] zero_src;
  wire [8:0] stack_top;
  wire [7:0] lit;
  wire [8:0] jump_target;
  wire [8:0] pc_inc;
  wire [4:0] fsel;
  wire [7:0] file_val;
  wire take_irq;

  // operand fields of the instruction word
  assign lit = instr_word[7:0];
  assign jump_target = instr_word[8:0];
  assign pc_inc = pc_addr + 9'h001;
  assign fsel = instr_word[4:0];
  // status and pc files read from inside; others from the outside file
  assign file_val = (fsel == `LCX_FILE_STATUS) ? status_out :
                    (fsel == `LCX_FILE_PC) ? pc_addr[7:0] : file_rd_data;
  // interrupt taken only between instructions while enabled
  assign take_irq = irq_request && irq_enable;

  lcx_stack u_stack (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .push(push),
    .pop(pop),
    .push_data(push_data),
    .top(stack_top)
  );

  // decode and next-state
  always @* begin
    pc_next = pc_inc;
    acc_next = acc_out;
    status_next = status_out;
    irq_en_next = irq_enable;
    push = 1'b0;
    pop = 1'b0;
    push_data = pc_inc;
    wr_en_next = 1'b0;
    wr_data_next = 8'h00;
    zero_upd = 1'b0;
    zero_src = 8'h00;
    if (take_irq) begin
      // vector to zero, save current address, block nesting
      push = 1'b1;
      push_data = pc_addr;
      pc_next = 9'h000;
      irq_en_next = 1'b0;
    end else if (instr_word == `LCX_OP_RETIRQ) begin
      pop = 1'b1;
      pc_next = stack_top;
      irq_en_next = 1'b1;
    end else if (instr_word[11:9] == `LCX_OP3_JUMP) begin
      pc_next = jump_target;
    end else begin
      case (instr_word[11:8])
        `LCX_OP4_AND: begin
          acc_next = acc_out & lit;
          zero_upd = 1'b1;
          zero_src = acc_out & lit;
        end
        `LCX_OP4_OR: begin
          acc_next = acc_out | lit;
          zero_upd = 1'b1;
          zero_src = acc_out | lit;
        end
        `LCX_OP4_XOR: begin
          acc_next = acc_out ^ lit;
          zero_upd = 1'b1;
          zero_src = acc_out ^ lit;
        end
        `LCX_OP4_MOVLIT: begin
          acc_next = lit;
        end
        `LCX_OP4_CALL: begin
          push = 1'b1;
          push_data = pc_inc;
          pc_next = {1'b0, lit}; // ninth bit forced low
        end
        `LCX_OP4_RETLIT: begin
          pop = 1'b1;
          pc_next = stack_top;
          acc_next = lit; // interrupt enable untouched
        end
        default: begin
          if (instr_word[11:6] == `LCX_OP6_MOVEFILE && instr_word[5]) begin
            // self-move: value rewritten unchanged, zero flag refreshed
            wr_en_next = 1'b1;
            wr_data_next = file_val;
            zero_upd = 1'b1;
            zero_src = file_val;
          end else if (instr_word[11:5] == `LCX_OP6_STOREACC && fsel == `LCX_FILE_PC) begin
            pc_next = {1'b0, acc_out};
          end else if (instr_word[11:5] == `LCX_OP6_STOREACC) begin
            wr_en_next = 1'b1;
            wr_data_next = acc_out;
          end else if (instr_word[11:9] == 3'h2 && fsel == `LCX_FILE_STATUS) begin
            // bit set/clear on status reaches carry, digit carry, zero
            status_next[instr_word[7:5]] = instr_word[8];
          end else if (instr_word[11:9] == 3'h3) begin
            // bit test skip: skip when bit equals the opcode's sense
            if (file_val[instr_word[7:5]] == instr_word[8]) begin
              pc_next = pc_addr + 9'h002;
            end
          end
        end
      endcase
    end
    if (zero_upd) begin
      status_next[`LCX_STAT_ZERO] = (zero_src == 8'h00);
    end
  end

  // state registers; ce low freezes everything
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      pc_addr <= `LCX_PC_RESET;
      acc_out <= `LCX_ACC_RESET;
      status_out <= `LCX_STATUS_RESET;
      irq_enable <= 1'b1;
      irq_taken <= 1'b0;
      file_wr_en <= 1'b0;
      file_addr <= 5'h00;
      file_wr_data <= 8'h00;
    end else if (ce) begin
      pc_addr <= pc_next;
      acc_out <= acc_next;
      status_out <= status_next;
      irq_enable <= irq_en_next;
      irq_taken <= take_irq; // pending request proceeds after return
      file_wr_en <= wr_en_next;
      file_addr <= fsel;
      file_wr_data <= wr_data_next;
    end
  end
endmodule // lcx_exec
`default_nettype wire

// file: pkg/lcx_defines.vh
// lcx_defines.vh: constants for the literal/control execution block
// assumes: included by bare name from core files; definitions only
`ifndef LCX_DEFINES_VH
`define LCX_DEFINES_VH
// opcodes (high bits of the 12-bit word; return-from-irq is the whole word)
`define LCX_OP4_AND 4'he
`define LCX_OP4_OR 4'hd
`define LCX_OP4_XOR 4'hf
`define LCX_OP4_MOVLIT 4'hc
`define LCX_OP4_CALL 4'h9
`define LCX_OP4_RETLIT 4'h8
`define LCX_OP3_JUMP 3'h5
`define LCX_OP_RETIRQ 12'h002
// file-group forms
`define LCX_OP6_MOVEFILE 6'h08
`define LCX_OP6_STOREACC 7'h01
// register-file addresses
`define LCX_FILE_PC 5'h02
`define LCX_FILE_STATUS 5'h03
// status bit positions
`define LCX_STAT_CARRY 0
`define LCX_STAT_DCARRY 1
`define LCX_STAT_ZERO 2
// reset values
`define LCX_PC_RESET 9'h1ff
`define LCX_ACC_RESET 8'h00
`define LCX_STATUS_RESET 8'h00
// return stack depth
`define LCX_STACK_DEPTH 2
`endif

// file: core/lcx_stack.v
// lcx_stack.v: 9-bit return-address stack, push and pop
// assumes: one clock, async active-high reset, enable gates all state
`timescale 1ns/10ps
`default_nettype none
`include "lcx_defines.vh"
module lcx_stack (
  input wire clk,
  input wire reset,
  input wire ce,
  input wire push,
  input wire pop,
  input wire [8:0] push_data,
  output wire [8:0] top
);
  reg [8:0] entry_reg [0:`LCX_STACK_DEPTH-1];
  integer i;

  // push shifts down, pop shifts up; overflow drops the oldest entry
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      for (i = 0; i < `LCX_STACK_DEPTH; i = i + 1) begin
        entry_reg[i] <= 9'h000;
      end
    end else if (ce && push) begin
      entry_reg[0] <= push_data; // full 9 bits kept
      for (i = 1; i < `LCX_STACK_DEPTH; i = i + 1) begin
        entry_reg[i] <= entry_reg[i-1];
      end
    end else if (ce && pop) begin
      for (i = 0; i < `LCX_STACK_DEPTH - 1; i = i + 1) begin
        entry_reg[i] <= entry_reg[i+1];
      end
    end
  end

  assign top = entry_reg[0];
endmodule // lcx_stack
`default_nettype wire

// file: bench/lcx_checker.sv
// lcx_checker.sv: port assertions for lcx_exec
// assumes: bound to lcx_exec, one clock, reset async high
`timescale 1ns/10ps
`default_nettype none
module lcx_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic irq_request,
  input wire logic irq_enable,
  input wire logic [11:0] instr_word,
  input wire logic [8:0] pc_addr,
  input wire logic [7:0] acc_out,
  input wire logic [7:0] status_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // an edge runs the word only if no interrupt steals it
  wire x = ce && !(irq_request && irq_enable);
  wire [3:0] op = instr_word[11:8];
  wire [7:0] k = instr_word[7:0];
  wire z = acc_out == 8'h00;
  sequence s_call; x && op == 4'h9; endsequence
  sequence s_ret; x && op == 4'h8; endsequence
  property p_or; x && op == 4'hd |=> acc_out == ($past(acc_out) | $past(k)) && status_out[2] == z; endproperty
  property p_xor; x && op == 4'hf |=> acc_out == ($past(acc_out) ^ $past(k)) && status_out[2] == z; endproperty
  property p_and; x && op == 4'he |=> acc_out == ($past(acc_out) & $past(k)); endproperty
  property p_jmp; x && instr_word[11:9] == 3'h5 |=> pc_addr == $past(instr_word[8:0]); endproperty
  property p_call; s_call |=> pc_addr == {1'b0, $past(k)}; endproperty
  // return lands one past the call, wherever the call sat
  property p_ret; s_call ##1 s_ret |=> pc_addr == $past(pc_addr, 2) + 9'h001 && acc_out == $past(k); endproperty
  property p_rfi; x && instr_word == 12'h002 |=> irq_enable && acc_out == $past(acc_out); endproperty
  property p_hold; (s_ret and !irq_enable) |=> !irq_enable; endproperty
  a_or: assert property (p_or) else $error("or result wrong");
  a_xor: assert property (p_xor) else $error("xor result wrong");
  a_and: assert property (p_and) else $error("and result wrong");
  a_jmp: assert property (p_jmp) else $error("jump target wrong");
  a_call: assert property (p_call) else $error("call target wrong");
  a_ret: assert property (p_ret) else $error("return wrong");
  a_rfi: assert property (p_rfi) else $error("irq return wrong");
  a_hold: assert property (p_hold) else $error("irq reenabled early");
endmodule // lcx_checker
bind lcx_exec lcx_checker i_lcx_checker (.clk, .reset, .ce, .irq_request, .irq_enable, .instr_word,
  .pc_addr, .acc_out, .status_out);
`default_nettype wire

// file: bench/lcx_tb_top.sv
// lcx_tb_top.sv: directed bench for lcx_exec
// assumes: instr_word stands in for program memory
`timescale 1ns/10ps
`default_nettype none
module lcx_tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic irq_request = 1'b0;
  logic ce = 1'b1;
  logic [11:0] instr_word = 12'hc00;
  logic [7:0] file_rd_data = 8'h00;
  wire [8:0] pc_addr;
  wire [7:0] acc_out, status_out, file_wr_data;
  wire [4:0] file_addr;
  wire irq_enable, irq_taken, file_wr_en;
  int err_total = 0;
  int n_checks = 0;
  always #12.5 clk = ~clk;
  lcx_exec i_lcx_exec (.clk, .reset, .ce, .instr_word, .irq_request, .file_rd_data, .pc_addr,
    .acc_out, .status_out, .irq_enable, .irq_taken, .file_wr_en, .file_addr, .file_wr_data);
  task summarize;
    if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [8:0] s, input logic [8:0] e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %0t got %h want %h", $time, s, e);
    end
  endtask
  // 0 pc, 1 acc, 2 status, 3 irq taken and enable
  function automatic logic [8:0] pick(input int s);
    return s == 0 ? pc_addr : s == 1 ? {1'b0, acc_out} : s == 2 ? {1'b0, status_out} : {7'h0, irq_taken, irq_enable};
  endfunction
  // one word per edge; inputs move 2 ns after it so nothing races
  task ex(input logic [11:0] w, input int s, input logic [8:0] e);
    instr_word = w;
    @(posedge clk);
    #2;
    chk(pick(s), e);
  endtask
  task t_status;
    ex(12'h503, 2, 9'h001);
    ex(12'h523, 2, 9'h003);
    ex(12'h543, 2, 9'h007);
    ex(12'h443, 2, 9'h003);
  endtask
  task t_logic;
    ex(12'hc49, 1, 9'h049);
    ex(12'he0f, 1, 9'h009);
    chk(pick(2), 9'h003);
    ex(12'hd80, 1, 9'h089);
    ex(12'hf89, 1, 9'h000);
    chk(pick(2), 9'h007);
    ex(12'hd01, 2, 9'h003);
  endtask
  // call from above the 8-bit range to prove the wide stack
  task t_ctrl;
    ex(12'hbf0, 0, 9'h1f0);
    ex(12'h9ae, 0, 9'h0ae);
    ex(12'h855, 0, 9'h1f1);
    chk(pick(1), 9'h055);
    ex(12'h022, 0, 9'h055);
  endtask
  task t_file;
    ex(12'h227, 2, 9'h007);
    chk({3'h0, file_wr_en, file_addr}, 9'h027);
    file_rd_data = 8'h3c;
    ex(12'h227, 2, 9'h003);
    chk({1'b0, file_wr_data}, 9'h03c);
  endtask
  // request stays high so the next one must wait for the irq return
  task t_irq;
    ex(12'ha40, 0, 9'h040);
    irq_request = 1'b1;
    ex(12'hc11, 3, 9'h002);
    ex(12'h920, 0, 9'h020);
    ex(12'h811, 3, 9'h000);
    chk(pick(0), 9'h001);
    ex(12'h002, 0, 9'h040);
    chk(pick(3), 9'h001);
    chk(pick(1), 9'h011);
    ex(12'hc00, 3, 9'h002);
    irq_request = 1'b0;
  endtask
  // enable low must freeze acc and pc; then the same word runs
  task t_freeze;
    ce = 1'b0;
    ex(12'hd22, 1, 9'h011);
    chk(pick(0), 9'h000);
    ce = 1'b1;
    ex(12'hd22, 1, 9'h033);
    chk(pick(0), 9'h001);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #2;
    reset = 1'b0;
    t_status;
    t_logic;
    t_ctrl;
    t_file;
    t_irq;
    t_freeze;
    summarize;
  end
endmodule // lcx_tb_top
`default_nettype wire
